// ==== sim/flash_self_program_control_monitor.sv ====
// Port checker for the flash self-programming controller
`default_nettype none
module flash_prog_monitor #(
  parameter integer ERASE_CYCLES = 20,
  parameter integer PROG_CYCLES = 5,
  parameter integer CNT_W = 32
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [1:0] REG_SEL,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  input wire logic [15:0] REG_RDATA,
  // Stall and flash control
  input wire logic CPU_STALL,
  input wire logic [23:0] FLASH_ADDR,
  input wire logic FLASH_ERASE_STB,
  input wire logic FLASH_PROG_STB,
  input wire logic FLASH_OP_DONE
);
  logic [31:0] cnt_r;
  logic erase_r;
  logic [17:0] w0_r, w1_r, w2_r;
  wire logic stb = FLASH_ERASE_STB | FLASH_PROG_STB;
  wire logic key_rd = REG_RD & (REG_SEL == 2'h1);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // ==========================================
  // Operation length and last three writes
  always_ff @(posedge CLK) begin
    if (RST) begin
      cnt_r <= 32'h0;
      erase_r <= 1'b0;
      w0_r <= 18'h0;
      w1_r <= 18'h0;
      w2_r <= 18'h0;
    end else begin
      if (stb) begin
        cnt_r <= 32'h1;
        erase_r <= FLASH_ERASE_STB;
      end else if (CPU_STALL) begin
        cnt_r <= cnt_r + 32'h1;
      end
      if (REG_WR) begin
        w0_r <= {REG_SEL, REG_WDATA};
        w1_r <= w0_r;
        w2_r <= w1_r;
      end
    end
  end
  // ==========================================
  // Assertions
  a_start_after_key: assert property (stb |-> w2_r == 18'h10055 && w1_r == 18'h100aa
    && w0_r[17:14] == 4'h3) else $error("start without unlock pair");
  a_done_count: assert property (FLASH_OP_DONE |->
    cnt_r == (erase_r ? ERASE_CYCLES : PROG_CYCLES) + 1) else $error("operation length wrong");
  a_stall_at_strobe: assert property (stb |-> CPU_STALL) else $error("no stall at start");
  a_stall_ends_done: assert property ($fell(CPU_STALL) |-> FLASH_OP_DONE)
    else $error("stall ended without done");
  a_prog_aligned: assert property (FLASH_PROG_STB |-> FLASH_ADDR[1:0] == 2'b10)
    else $error("program on odd boundary");
  a_strobe_single: assert property (stb |=> !stb && CPU_STALL)
    else $error("strobe not single");
  a_addr_held: assert property (CPU_STALL && $past(CPU_STALL) |-> $stable(FLASH_ADDR))
    else $error("address moved while busy");
  a_key_unreadable: assert property ($past(key_rd) |-> REG_RDATA == 16'h0000)
    else $error("key register readable");
  c_erase: cover property (FLASH_ERASE_STB);
  c_prog: cover property (FLASH_PROG_STB);
  c_done: cover property (FLASH_OP_DONE);
endmodule
bind flash_self_program_control flash_prog_monitor #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES), .CNT_W(CNT_W)) u_mon (.CLK(CLK), .RST(RST),
  .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
  .REG_RDATA(REG_RDATA), .CPU_STALL(CPU_STALL), .FLASH_ADDR(FLASH_ADDR),
  .FLASH_ERASE_STB(FLASH_ERASE_STB), .FLASH_PROG_STB(FLASH_PROG_STB),
  .FLASH_OP_DONE(FLASH_OP_DONE));
`default_nettype wire

// ==== sim/tb.sv ====
// Testbench for the flash self-programming controller
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 0, RST = 1, REG_WR = 0, REG_RD = 0;
  logic CPU_STALL, FLASH_ERASE_STB, FLASH_PROG_STB, FLASH_OP_DONE;
  logic [1:0] REG_SEL = 0;
  logic [15:0] REG_WDATA = 0, REG_RDATA, v;
  logic [23:0] FLASH_ADDR;
  int num_errors = 0;
  int check_count = 0;
  localparam int ERASE_N = 20;
  localparam int PROG_N = 5;
  flash_self_program_control #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) u_dut (.CLK(CLK),
    .RST(RST), .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .CPU_STALL(CPU_STALL), .FLASH_ADDR(FLASH_ADDR),
    .FLASH_ERASE_STB(FLASH_ERASE_STB), .FLASH_PROG_STB(FLASH_PROG_STB),
    .FLASH_OP_DONE(FLASH_OP_DONE));
  // ==========================================
  // Shared bus and compare tasks
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [15:0] data);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_SEL <= sel;
    REG_WDATA <= data;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] sel, output logic [15:0] data);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_SEL <= sel;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    data = REG_RDATA;
  endtask
  // Load address, unlock, start, then judge the outcome
  task automatic run_op(input logic [23:0] a, input logic [15:0] k2, input bit mid,
      input logic [15:0] ctl, input bit go);
    bit seen;
    int i;
    int n_exp;
    seen = 0;
    n_exp = (ctl[3:0] == 4'h3) ? ERASE_N : PROG_N;
    wr(2'h2, {8'h00, a[23:16]});
    wr(2'h3, a[15:0]);
    wr(2'h1, 16'h0055);
    if (mid) wr(2'h3, a[15:0]);
    wr(2'h1, k2);
    wr(2'h0, ctl);
    for (i = 0; i < 4 && !seen; i++) begin
      #1;
      seen = FLASH_ERASE_STB === 1'b1 || FLASH_PROG_STB === 1'b1;
      if (!seen) @(posedge CLK);
    end
    check("started", seen, go);
    if (seen) check("addr", FLASH_ADDR, a);
    if (seen) check("kind", FLASH_PROG_STB, ctl[3:0] == 4'h1);
    if (seen) begin
      check("stall_on", CPU_STALL, 1'b1);
      rd(2'h0, v);
      check("start_busy", v[15], 1'b1);
      i = 2;
      while (i < 60 && FLASH_OP_DONE !== 1'b1) begin
        @(posedge CLK);
        #1;
        i++;
      end
      check("op_cycles", 24'(i), 24'(n_exp + 1));
      check("stall_off", CPU_STALL, 1'b0);
    end
    rd(2'h0, v);
    check("start_bit", v[15], 1'b0);
    check("err_bit", v[13], !go);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_erase();
    run_op(24'h123456, 16'h00aa, 0, 16'hc003, 1);
    rd(2'h2, v);
    check("upper", v, 16'h0012);
    rd(2'h3, v);
    check("lower", v, 16'h3456);
    rd(2'h1, v);
    check("key_rd", v, 16'h0000);
  endtask
  task automatic t_prog();
    logic [3:0] n;
    for (n = 4'h2; n < 4'hc; n = n + 4'h2) begin
      run_op({20'h00010, n}, 16'h00aa, 0, 16'hc001, n[1:0] == 2'b10);
    end
  endtask
  task automatic t_badkey();
    run_op(24'h000400, 16'h00ab, 0, 16'hc003, 0);
    run_op(24'h000400, 16'h00aa, 1, 16'hc003, 0);
    run_op(24'h000400, 16'h00aa, 0, 16'hc002, 0);
    wr(2'h0, 16'h4001);
    rd(2'h0, v);
    check("ctl_update", v, 16'h4001);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // Clock, watchdog and main sequence
  initial begin
    forever #25 CLK = ~CLK;
  end
  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    rd(2'h0, v);
    check("ctl_reset", v, 16'h0000);
    t_erase();
    t_prog();
    t_badkey();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== src/flash_op_timer.v ====
// Down-counter that times one flash erase or program operation
`default_nettype none

module flash_op_timer #(
  parameter integer CNT_W = 32
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Control
  input wire load,
  input wire [CNT_W-1:0] load_val,
  // Status
  output reg running,
  output reg done
);

  reg [CNT_W-1:0] cnt_r;

  // ==========================================================
  // Countdown; done pulses once as the count expires
  always @(posedge CLK) begin
    if (RST) begin
      cnt_r <= {CNT_W{1'b0}};
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_r <= load_val;
        running <= 1'b1;
      end else if (running) begin
        if (cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

// ==== src/flash_self_program_control.v ====
// Flash self-programming controller: registers, unlock key and operation sequencing
//
// Behaviour
// (RQ1) Four registers: control, unlock key, upper address, lower address.
// (RQ2) Control register enables and starts erase and program operations.
// (RQ3) Key register is write-only, used only as write protection.
// (RQ4) Writes 0x55 then 0xAA to key must precede a start.
// (RQ5) Both address registers concatenate into a 24-bit effective address.
// (RQ6) Upper register holds address bits 23:16; lower holds bits 15:0.
// (RQ7) Start bit begins operation; hardware clears it at completion.
// (RQ8) Processor is stalled while an operation is in progress.
// (RQ9) Program writes two adjacent words, only on every other word boundary.
// (RQ10) Erase clears one page chosen by the effective address.
// (RQ11) A wrong value or intervening write breaks unlock; no operation starts.
`include "flash_self_program_defines.vh"
`default_nettype none

module flash_self_program_control #(
  parameter integer ERASE_CYCLES = `PAGE_ERASE_CYC,
  parameter integer PROG_CYCLES = `WORD_WRITE_CYC,
  parameter integer CNT_W = 32
) (
  // Clock and reset
  input wire CLK,
  input wire RST,
  // Core register access
  input wire [1:0] REG_SEL,
  input wire REG_WR,
  input wire REG_RD,
  input wire [15:0] REG_WDATA,
  output reg [15:0] REG_RDATA,
  // Core stall
  output reg CPU_STALL,
  // Flash array control
  output reg [23:0] FLASH_ADDR,
  output reg FLASH_ERASE_STB,
  output reg FLASH_PROG_STB,
  output reg FLASH_OP_DONE
);

  // ==========================================================
  // Unlock key states
  localparam [1:0] KEY_IDLE = 2'b00;
  localparam [1:0] KEY_HALF = 2'b01;
  localparam [1:0] KEY_ARMED = 2'b10;

  // Reset value of the address registers, taken apart by halves
  localparam [23:0] ADDR_RST = `ADDR_RESET;

  reg [1:0] key_r;
  reg [1:0] key_nxt;
  reg start_r;
  reg enable_r;
  reg error_r;
  reg [3:0] op_r;
  reg [7:0] addr_upper_r;
  reg [15:0] addr_lower_r;
  reg busy_r;
  reg timer_load;
  reg [CNT_W-1:0] timer_val;
  wire timer_running;
  wire timer_done;
  wire [23:0] eff_addr;
  wire ctl_wr;
  wire key_wr;
  wire start_req;
  wire op_is_erase;
  wire op_is_prog;
  wire prog_aligned;
  wire go;

  // ==========================================================
  // Effective address and decode
  assign eff_addr = {addr_upper_r, addr_lower_r}; // RQ5 RQ6
  assign ctl_wr = REG_WR && (REG_SEL == `REG_IDX_CONTROL);
  assign key_wr = REG_WR && (REG_SEL == `REG_IDX_KEY);
  assign start_req = ctl_wr && REG_WDATA[`CTL_START_BIT] && REG_WDATA[`CTL_ENABLE_BIT]
    && !busy_r; // RQ2
  assign op_is_erase = REG_WDATA[`CTL_OP_MSB:`CTL_OP_LSB] == `OP_ERASE_PAGE;
  assign op_is_prog = REG_WDATA[`CTL_OP_MSB:`CTL_OP_LSB] == `OP_PROGRAM_PAIR;
  assign prog_aligned = (eff_addr & `PROG_ALIGN_MASK) == `PROG_ALIGN_VAL; // RQ9
  // Start only when armed and the request is valid
  assign go = start_req && (key_r == KEY_ARMED)
    && (op_is_erase || (op_is_prog && prog_aligned)); // RQ4 RQ11

  // ==========================================================
  // Key sequence: any other write breaks it
  always @* begin
    key_nxt = KEY_IDLE;
    case (key_r)
      KEY_IDLE: begin
        if (key_wr && REG_WDATA == `KEY_FIRST) key_nxt = KEY_HALF; // RQ4
        else key_nxt = KEY_IDLE;
      end
      KEY_HALF: begin
        if (key_wr && REG_WDATA == `KEY_SECOND) key_nxt = KEY_ARMED; // RQ4
        else if (key_wr && REG_WDATA == `KEY_FIRST) key_nxt = KEY_HALF;
        else if (REG_WR) key_nxt = KEY_IDLE; // RQ11
        else key_nxt = KEY_HALF;
      end
      KEY_ARMED: begin
        if (key_wr && REG_WDATA == `KEY_FIRST) key_nxt = KEY_HALF;
        else if (REG_WR) key_nxt = KEY_IDLE; // RQ11
        else key_nxt = KEY_ARMED;
      end
      default: key_nxt = KEY_IDLE;
    endcase
  end

  // Key state register
  always @(posedge CLK) begin
    if (RST) begin
      key_r <= KEY_IDLE;
    end else begin
      key_r <= key_nxt;
    end
  end

  // ==========================================================
  // Upper address half; writes are refused while an operation runs
  always @(posedge CLK) begin
    if (RST) addr_upper_r <= ADDR_RST[`ADDR_UPPER_MSB:`ADDR_UPPER_LSB];
    else if (REG_WR && !busy_r && (REG_SEL == `REG_IDX_ADDR_UPPER)) begin
      addr_upper_r <= REG_WDATA[7:0]; // RQ6
    end
  end

  // Lower address half, same refusal while busy
  always @(posedge CLK) begin
    if (RST) addr_lower_r <= ADDR_RST[`ADDR_LOWER_MSB:0];
    else if (REG_WR && !busy_r && (REG_SEL == `REG_IDX_ADDR_LOWER)) begin
      addr_lower_r <= REG_WDATA; // RQ6
    end
  end

  // ==========================================================
  // Control register and operation sequencing
  always @(posedge CLK) begin
    if (RST) begin
      start_r <= 1'b0;
      enable_r <= 1'b0;
      error_r <= 1'b0;
      op_r <= 4'h0;
      busy_r <= 1'b0;
      FLASH_ADDR <= `ADDR_RESET;
      FLASH_ERASE_STB <= 1'b0;
      FLASH_PROG_STB <= 1'b0;
      FLASH_OP_DONE <= 1'b0;
    end else begin
      FLASH_ERASE_STB <= 1'b0;
      FLASH_PROG_STB <= 1'b0;
      FLASH_OP_DONE <= 1'b0;
      if (busy_r) begin
        if (timer_done && !timer_running) begin
          busy_r <= 1'b0;
          start_r <= 1'b0; // RQ7
          FLASH_OP_DONE <= 1'b1;
        end
      end else if (ctl_wr) begin
        enable_r <= REG_WDATA[`CTL_ENABLE_BIT]; // RQ2
        op_r <= REG_WDATA[`CTL_OP_MSB:`CTL_OP_LSB];
        if (go) begin
          start_r <= 1'b1; // RQ7
          busy_r <= 1'b1;
          error_r <= 1'b0;
          FLASH_ADDR <= eff_addr; // RQ5
          FLASH_ERASE_STB <= op_is_erase; // RQ10
          FLASH_PROG_STB <= op_is_prog; // RQ9
        end else if (start_req) begin
          error_r <= 1'b1; // RQ11
        end else if (!REG_WDATA[`CTL_ERROR_BIT]) begin
          error_r <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Operation timer load
  always @* begin
    timer_load = go;
    if (op_is_erase) timer_val = ERASE_CYCLES[CNT_W-1:0];
    else timer_val = PROG_CYCLES[CNT_W-1:0];
  end

  flash_op_timer #(
    .CNT_W(CNT_W)
  ) u_timer (
    .CLK(CLK),
    .RST(RST),
    .load(timer_load),
    .load_val(timer_val),
    .running(timer_running),
    .done(timer_done)
  );

  // ==========================================================
  // Processor stall while an operation runs
  always @(posedge CLK) begin
    if (RST) begin
      CPU_STALL <= 1'b0;
    end else begin
      CPU_STALL <= go || (busy_r && !timer_done); // RQ8
    end
  end

  // ==========================================================
  // Read-back; key register reads zero
  always @(posedge CLK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_SEL)
        `REG_IDX_CONTROL: REG_RDATA <= {start_r, enable_r, error_r, 9'h000, op_r}; // RQ2
        `REG_IDX_KEY: REG_RDATA <= 16'h0000; // RQ3
        `REG_IDX_ADDR_UPPER: REG_RDATA <= {8'h00, addr_upper_r}; // RQ1
        `REG_IDX_ADDR_LOWER: REG_RDATA <= addr_lower_r; // RQ1
        default: REG_RDATA <= 16'h0000;
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ==== src/flash_self_program_defines.vh ====
// Constants for the flash self-programming controller
`ifndef FLASH_SELF_PROGRAM_DEFINES_VH
`define FLASH_SELF_PROGRAM_DEFINES_VH

// ==========================================================
// Register indices on the core access port
`define REG_IDX_CONTROL 2'h0
`define REG_IDX_KEY 2'h1
`define REG_IDX_ADDR_UPPER 2'h2
`define REG_IDX_ADDR_LOWER 2'h3

// ==========================================================
// Control register fields
`define CTL_START_BIT 15
`define CTL_ENABLE_BIT 14
`define CTL_ERROR_BIT 13
`define CTL_OP_MSB 3
`define CTL_OP_LSB 0
`define CTL_RESET 16'h0000
`define OP_PROGRAM_PAIR 4'h1
`define OP_ERASE_PAGE 4'h3

// ==========================================================
// Unlock key values
`define KEY_FIRST 16'h0055
`define KEY_SECOND 16'h00aa

// ==========================================================
// Address layout and program alignment
`define ADDR_UPPER_MSB 23
`define ADDR_UPPER_LSB 16
`define ADDR_LOWER_MSB 15
`define ADDR_RESET 24'h000000
`define PROG_ALIGN_MASK 24'h000003
`define PROG_ALIGN_VAL 24'h000002

// ==========================================================
// Timing: least times in ns, cycle counts rounded up
`define CLK_PERIOD_NS 50
`define PAGE_ERASE_NS 17700000
`define WORD_WRITE_NS 41700
`define PAGE_ERASE_CYC ((`PAGE_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WORD_WRITE_CYC ((`WORD_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif
